// ===== hdl/ppm_port_ctrl.sv
// Port pin mode controller: ports 0 to 10, alternate functions,
// pull-ups, open-drain, interrupt edges and key-return flag.
// Assumes software settings arrive as steady levels on plain ports.
`timescale 1ns/100ps
module ppm_port_ctrl
  import ppm_pkg::*;
#(
  parameter bit HAS_TWOWIRE = 1'b1, // Two-wire bus variant
  parameter bit HAS_EXA     = 1'b1  // Access status variant
) (
  input  wire logic              sys_clk,            // 40 MHz clock
  input  wire logic              rst,                // Async reset
  input  wire logic [NB-1:0]     pinIn,              // Pin levels
  output logic      [NB-1:0]     pinOut,             // Pin drive level
  output logic      [NB-1:0]     pinOe,              // Pin drive enable
  output logic      [NB-1:0]     pullEn,             // Pull-up connect
  output logic      [NB-1:0]     portRead,           // Port read data
  input  wire logic [NB-1:0]     portDir,            // 1 = input
  input  wire logic [NB-1:0]     portLatch,          // Output latches
  input  wire logic [NB-1:0]     portAlt,            // 1 = alternate
  input  wire logic [NB-1:0]     pullCfg,            // Per-bit pull-ups
  input  wire logic [7:0]        pullupOption,       // Port-wide pulls
  input  wire logic [7:0]        port2OpenDrainCtrl, // Port 2 OD select
  input  wire logic [7:0]        p2AltOut,           // Serial data
  input  wire logic [7:0]        p2AltOe,            // Serial drive
  input  wire logic [7:0]        p3AltOut,           // Timer data
  input  wire logic [7:0]        p3AltOe,            // Timer drive
  input  wire logic [P7_W-1:0]   p7AltOut,           // Serial data
  input  wire logic [P7_W-1:0]   p7AltOe,            // Serial drive
  input  wire logic [P10_W-1:0]  p10AltOut,          // Timer data
  input  wire logic [P10_W-1:0]  p10AltOe,           // Timer drive
  input  wire logic              extAccessStatus,    // Bus access status
  input  wire logic [7:0]        lowAddrDataBus,     // Address/data out
  input  wire logic              lowAddrDataOe,      // Address/data drive
  input  wire logic [7:0]        midAddressBus,      // Address 8 to 15
  input  wire logic [3:0]        highAddressBus,     // Address 16 to 19
  input  wire logic [7:0]        lowAddressBus,      // Address 0 to 7
  input  wire logic              readStrobe,         // Read strobe
  input  wire logic              writeStrobe,        // Write strobe
  input  wire logic              addressLatchStrobe, // Address latch
  input  wire logic              waitEnable,         // Wait pin in use
  input  wire logic [P1_W-1:0]   analogInputs,       // Port 1 pins
  input  wire logic [P1_W-1:0]   analogSel,          // 1 = analog
  output logic      [P1_W-1:0]   port1Read,          // Port 1 read
  input  wire logic [P0_W-1:0]   riseEdgeEnable,     // Rising enables
  input  wire logic [P0_W-1:0]   fallEdgeEnable,     // Falling enables
  input  wire logic              nmiSelect,          // Bit 2 is NMI
  output logic      [P0_W-1:0]   extIrqInputs,       // Interrupt pulses
  output logic                   nmiRequest,         // NMI pulse
  output logic                   rtpTrigger,         // RTP trigger pulse
  input  wire logic              keyReturnClear,     // Clear key flag
  output logic                   keyReturnIrqFlag    // Key-return flag
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////

  ppm_pin_if #(.W(NB)) pins ();         // Bank pin group

  logic [NB-1:0]   bankAlt;             // Resolved alternate select
  logic [NB-1:0]   bankAltOut;          // Resolved alternate data
  logic [NB-1:0]   bankAltOe;           // Resolved alternate drive
  logic [NB-1:0]   bankPull;            // Resolved pull-up request
  logic [NB-1:0]   bankOd;              // Resolved open-drain bits
  logic [P0_W-1:0] irqPulse;            // Raw interrupt edges
  logic [P0_W-1:0] irqRiseEn;           // Enables gated by mode
  logic [P0_W-1:0] irqFallEn;
  logic [7:0]      krPulse;             // Port 8 falling edges
  logic [7:0]      krFallEn;            // All falling edges armed
  logic [7:0]      krRiseEn;            // No rising edges

  logic [P0_W-1:0] next_extIrqInputs;
  logic            next_nmiRequest;
  logic            next_rtpTrigger;
  logic            next_keyReturnIrqFlag;
  logic [P1_W-1:0] next_port1Read;

  //////////////////////////////////////////////////////////////////////
  // Pin group wiring
  //////////////////////////////////////////////////////////////////////

  // Outputs come straight from the bank flops
  assign pins.pinIn = pinIn;
  assign pinOut     = pins.pinOut;
  assign pinOe      = pins.pinOe;
  assign pullEn     = pins.pullEn;
  assign portRead   = pins.readData;

  //////////////////////////////////////////////////////////////////////
  // Per-port mode resolution
  //////////////////////////////////////////////////////////////////////

  // Builds the per-bit bank settings from each port's own scheme
  always_comb begin
    bankAlt    = portAlt;
    bankAltOut = '0;
    bankAltOe  = '0;
    bankPull   = '0;
    bankOd     = '0;

    // Port 0: interrupt inputs never drive the pin
    bankPull[P0_BASE +: P0_W] = pullCfg[P0_BASE +: P0_W];

    // Port 2: serial functions, two-wire pins open-drain
    bankAltOut[P2_BASE +: BYTE_W] = p2AltOut;
    bankAltOe[P2_BASE +: BYTE_W]  = p2AltOe;
    bankPull[P2_BASE +: BYTE_W]   = pullCfg[P2_BASE +: BYTE_W];
    if (HAS_TWOWIRE) begin
      bankOd[P2_BASE +: BYTE_W] = port2OpenDrainCtrl & P2_OD_MASK;
    end

    // Port 3: timer functions, access status on the top pin
    bankAltOut[P3_BASE +: BYTE_W] = p3AltOut;
    bankAltOe[P3_BASE +: BYTE_W]  = p3AltOe;
    bankPull[P3_BASE +: BYTE_W]   = pullCfg[P3_BASE +: BYTE_W];
    if (HAS_EXA) begin
      bankAltOut[P3_BASE + P3_EXA_BIT] = extAccessStatus;
      bankAltOe[P3_BASE + P3_EXA_BIT]  = 1'b1;
    end

    // Port 4: multiplexed address/data, shared pull-up bit
    bankAltOut[P4_BASE +: BYTE_W] = lowAddrDataBus;
    bankAltOe[P4_BASE +: BYTE_W]  = {BYTE_W{lowAddrDataOe}};
    bankPull[P4_BASE +: BYTE_W]   = {BYTE_W{pullupOption[PUO_P4]}} &
      (portDir[P4_BASE +: BYTE_W] | portAlt[P4_BASE +: BYTE_W]);

    // Port 5: middle address byte, shared pull-up bit
    bankAltOut[P5_BASE +: BYTE_W] = midAddressBus;
    bankAltOe[P5_BASE +: BYTE_W]  = '1;
    bankPull[P5_BASE +: BYTE_W]   = {BYTE_W{pullupOption[PUO_P5]}} &
      (portDir[P5_BASE +: BYTE_W] | portAlt[P5_BASE +: BYTE_W]);

    // Port 6: high address, strobes and wait input
    bankAltOut[P6_BASE +: BYTE_W] = {addressLatchStrobe, 1'b0,
                                     writeStrobe, readStrobe,
                                     highAddressBus};
    bankAltOe[P6_BASE +: BYTE_W]  = P6_OE_MASK;
    bankPull[P6_BASE +: BYTE_W]   = {BYTE_W{pullupOption[PUO_P6]}} &
      (portDir[P6_BASE +: BYTE_W] | portAlt[P6_BASE +: BYTE_W]);
    if (!waitEnable) begin
      bankAlt[P6_BASE + P6_WAIT] = 1'b0;
    end

    // Port 7: serial functions, per-bit pull-ups
    bankAltOut[P7_BASE +: P7_W] = p7AltOut;
    bankAltOe[P7_BASE +: P7_W]  = p7AltOe;
    bankPull[P7_BASE +: P7_W]   = pullCfg[P7_BASE +: P7_W];

    // Port 8: low address byte, per-bit pull-ups in both modes
    bankAltOut[P8_BASE +: BYTE_W] = lowAddressBus;
    bankAltOe[P8_BASE +: BYTE_W]  = '1;
    bankPull[P8_BASE +: BYTE_W]   = pullCfg[P8_BASE +: BYTE_W];

    // Port 9: open-drain only, no alternate, no pull-ups
    bankAlt[P9_BASE +: P9_W] = '0;
    bankOd[P9_BASE +: P9_W]  = '1;

    // Port 10: timer functions, per-bit pull-ups
    bankAltOut[P10_BASE +: P10_W] = p10AltOut;
    bankAltOe[P10_BASE +: P10_W]  = p10AltOe;
    bankPull[P10_BASE +: P10_W]   = pullCfg[P10_BASE +: P10_W];
  end

  //////////////////////////////////////////////////////////////////////
  // Pin bank
  //////////////////////////////////////////////////////////////////////

  // Per-bit direction for ports 0, 2 to 10
  ppm_pin_bank #(
    .W       (NB)
  ) u_bank (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    (pins),
    .dirIn   (portDir),
    .latch   (portLatch),
    .altSel  (bankAlt),
    .altOut  (bankAltOut),
    .altOe   (bankAltOe),
    .pullReq (bankPull),
    .odMask  (bankOd)
  );

  //////////////////////////////////////////////////////////////////////
  // Edge detection
  //////////////////////////////////////////////////////////////////////

  // Port 0 edges count only on pins set to interrupt input; port 8 falls always count
  always_comb begin
    irqRiseEn = riseEdgeEnable & portAlt[P0_BASE +: P0_W];
    irqFallEn = fallEdgeEnable & portAlt[P0_BASE +: P0_W];
    krRiseEn  = '0;
    krFallEn  = '1;
  end

  // External interrupt inputs of port 0
  ppm_edge_detect #(
    .W         (P0_W)
  ) u_irq_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sampleIn  (pinIn[P0_BASE +: P0_W]),
    .riseEn    (irqRiseEn),
    .fallEn    (irqFallEn),
    .edgePulse (irqPulse)
  );

  // Key-return falling edges of port 8
  ppm_edge_detect #(
    .W         (BYTE_W)
  ) u_kr_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sampleIn  (pinIn[P8_BASE +: BYTE_W]),
    .riseEn    (krRiseEn),
    .fallEn    (krFallEn),
    .edgePulse (krPulse)
  );

  //////////////////////////////////////////////////////////////////////
  // Event outputs, key-return flag and port 1 read
  //////////////////////////////////////////////////////////////////////

  // Next values of the event and read registers
  always_comb begin
    next_extIrqInputs = irqPulse;
    if (nmiSelect) begin
      next_extIrqInputs[NMI_BIT] = 1'b0;
    end
    next_nmiRequest = irqPulse[NMI_BIT] & nmiSelect;
    next_rtpTrigger = irqPulse[RTP_BIT];
    // A new edge wins over a clear in the same cycle
    if (|krPulse) begin
      next_keyReturnIrqFlag = 1'b1;
    end else if (keyReturnClear) begin
      next_keyReturnIrqFlag = 1'b0;
    end else begin
      next_keyReturnIrqFlag = keyReturnIrqFlag;
    end
    // Analog pins read as zero; software must not use them
    next_port1Read = analogInputs & ~analogSel;
  end

  // Event and read registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extIrqInputs     <= {P0_W{RST_LVL}};
      nmiRequest       <= RST_LVL;
      rtpTrigger       <= RST_LVL;
      keyReturnIrqFlag <= RST_LVL;
      port1Read        <= {P1_W{RST_LVL}};
    end else begin
      extIrqInputs     <= next_extIrqInputs;
      nmiRequest       <= next_nmiRequest;
      rtpTrigger       <= next_rtpTrigger;
      keyReturnIrqFlag <= next_keyReturnIrqFlag;
      port1Read        <= next_port1Read;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////

  a_nmi_from_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    irqPulse[NMI_BIT] && nmiSelect |=> nmiRequest && !extIrqInputs[NMI_BIT])
    else $error("NMI edge not routed to NMI request");

  a_rtp_trigger_follows: assert property (
    @(posedge sys_clk) disable iff (rst)
    rtpTrigger == $past(irqPulse[RTP_BIT]))
    else $error("RTP trigger not one cycle after edge");

  a_keyret_flag_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    |krPulse |=> keyReturnIrqFlag)
    else $error("key-return edge lost");

  a_keyret_flag_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    keyReturnIrqFlag && !keyReturnClear |=> keyReturnIrqFlag)
    else $error("key-return flag dropped without clear");

  a_port1_read_mask: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 (port1Read == ($past(analogInputs) & ~$past(analogSel))))
    else $error("port 1 read wrong");

  a_port9_no_pull: assert property (
    @(posedge sys_clk) disable iff (rst)
    pullEn[P9_BASE +: P9_W] == '0)
    else $error("port 9 pull-up connected");

  a_port4_pull_all: assert property (
    @(posedge sys_clk) disable iff (rst)
    pullupOption[PUO_P4] && (&portDir[P4_BASE +: BYTE_W])
    |=> (&pullEn[P4_BASE +: BYTE_W]))
    else $error("port 4 input pull-ups not connected");

  a_wait_pin_io: assert property (
    @(posedge sys_clk) disable iff (rst)
    !waitEnable && !portDir[P6_BASE + P6_WAIT]
    |=> pinOe[P6_BASE + P6_WAIT] == 1'b1)
    else $error("wait pin not usable as output");

  a_port2_open_drain: assert property (
    @(posedge sys_clk) disable iff (rst)
    HAS_TWOWIRE && port2OpenDrainCtrl[5]
    |=> !(pinOe[P2_BASE + 5] && pinOut[P2_BASE + 5]))
    else $error("port 2 open-drain bit driven high");

  a_port0_no_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 ((pinOe[P0_BASE +: P0_W] & $past(portAlt[P0_BASE +: P0_W])) == '0))
    else $error("interrupt input pin driven");

  a_irq_needs_alt: assert property (
    @(posedge sys_clk) disable iff (rst)
    portAlt[P0_BASE +: P0_W] == '0 |=> irqPulse == '0)
    else $error("edge reported on a port mode pin");

  a_access_status_out: assert property (
    @(posedge sys_clk) disable iff (rst)
    HAS_EXA && portAlt[P3_BASE + P3_EXA_BIT]
    |=> pinOe[P3_BASE + P3_EXA_BIT]
        && pinOut[P3_BASE + P3_EXA_BIT] == $past(extAccessStatus))
    else $error("access status not on its pin");

  a_port5_addr_out: assert property (
    @(posedge sys_clk) disable iff (rst)
    &portAlt[P5_BASE +: BYTE_W]
    |=> pinOut[P5_BASE +: BYTE_W] == $past(midAddressBus))
    else $error("middle address not on port 5");

  a_port6_strobe_out: assert property (
    @(posedge sys_clk) disable iff (rst)
    portAlt[P6_BASE + 7] |=> pinOe[P6_BASE + 7]
    && pinOut[P6_BASE + 7] == $past(addressLatchStrobe))
    else $error("address latch strobe not on port 6");

  a_port8_pull_bits: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 (pullEn[P8_BASE +: BYTE_W] == $past(pullCfg[P8_BASE +: BYTE_W])))
    else $error("port 8 pull-up not per bit");

  a_port9_never_high: assert property (
    @(posedge sys_clk) disable iff (rst)
    pinOut[P9_BASE +: P9_W] == '0)
    else $error("port 9 pin driven high");

endmodule : ppm_port_ctrl

// ===== hdl/ppm_pkg.sv
// Constants for the port pin mode controller: pin map, bit positions,
// masks and reset levels. Assumes a single clock and synchronous pins.
// Overview of operation
// - Port 0: seven pins, per-bit direction
// - Port 0: per-bit pull-up, either direction
// - Port or alternate mode chosen per pin
// - Seven interrupt inputs: rising, falling or both
// - Non-maskable request uses same edge enables
// - Third interrupt edge also triggers real-time output
// - Port 1: eight input pins, no pull-ups
// - Port 1 analog pins read as zero
// - Port 2: eight pins, per-bit direction, pull-up
// - Port 2 bits 5, 7 selectable open-drain
// - Port 3: eight pins, per-bit direction, pull-up
// - Port 3 pin outputs external access status
// - Port 4 input pull-ups by option bit 4
// - Port 4 carries address/data; pull-up when bit set
// - Port 5 pull-up bit 5; middle address
// - Port 6: high address and bus strobes
// - Port 6 pull-ups by option bit 6
// - Unused wait pin stays ordinary I/O
// - Port 7: three pins, per-bit direction, pull-up
// - Port 8 falling edge sets key-return flag
// - Port 8 per-bit pull-ups; low address
// - Port 9: six open-drain pins, no pull-ups
// - Port 10: four pins, per-bit direction, pull-up
package ppm_pkg;
  localparam int unsigned NB      = 68; // Pins held in the bank
  localparam int unsigned P0_BASE = 0;  // Bank offset of each port
  localparam int unsigned P2_BASE = 7;
  localparam int unsigned P3_BASE = 15;
  localparam int unsigned P4_BASE = 23;
  localparam int unsigned P5_BASE = 31;
  localparam int unsigned P6_BASE = 39;
  localparam int unsigned P7_BASE = 47;
  localparam int unsigned P8_BASE = 50;
  localparam int unsigned P9_BASE = 58;
  localparam int unsigned P10_BASE = 64;
  localparam int unsigned P0_W    = 7;  // Port widths
  localparam int unsigned P1_W    = 8;
  localparam int unsigned P7_W    = 3;
  localparam int unsigned P9_W    = 6;
  localparam int unsigned P10_W   = 4;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned NMI_BIT = 2;  // Interrupt input shared with NMI
  localparam int unsigned RTP_BIT = 2;  // Interrupt input that triggers RTP
  localparam int unsigned PUO_P4  = 4;  // Pull-up option bit positions
  localparam int unsigned PUO_P5  = 5;
  localparam int unsigned PUO_P6  = 6;
  localparam int unsigned P3_EXA_BIT = 7; // Access status pin of port 3
  localparam int unsigned P6_WAIT = 6;  // Wait input pin of port 6
  localparam logic [7:0]  P2_OD_MASK = 8'hA0; // Open-drain capable bits
  localparam logic [7:0]  P6_OE_MASK = 8'hBF; // Port 6 bus outputs
  localparam logic        RST_LVL = 1'b0; // Level of all flops at reset
endpackage : ppm_pkg

// ===== hdl/ppm_pin_if.sv
// Pin-side signals passed between the controller and its pin bank.
// Assumes the bank owns every output flop of the group.
`timescale 1ns/100ps
interface ppm_pin_if #(parameter int unsigned W = 8);
  logic [W-1:0] pinIn;    // Pin levels seen
  logic [W-1:0] pinOut;   // Driven levels
  logic [W-1:0] pinOe;    // Drive enables
  logic [W-1:0] pullEn;   // Pull-up connects
  logic [W-1:0] readData; // Port read value
  modport bank (input pinIn, output pinOut, pinOe, pullEn, readData);
  modport core (output pinIn, input pinOut, pinOe, pullEn, readData);
endinterface : ppm_pin_if

// ===== hdl/ppm_edge_detect.sv
// Edge detector with per-bit rising and falling enables.
// Assumes the sampled inputs are synchronous to sys_clk.
`timescale 1ns/100ps
module ppm_edge_detect
  import ppm_pkg::*;
#(
  parameter int unsigned W = 7 // Inputs watched
) (
  input  wire logic         sys_clk,   // System clock
  input  wire logic         rst,       // Async reset
  input  wire logic [W-1:0] sampleIn,  // Levels watched
  input  wire logic [W-1:0] riseEn,    // Rising enables
  input  wire logic [W-1:0] fallEn,    // Falling enables
  output logic      [W-1:0] edgePulse  // One-cycle edges
);
  logic [W-1:0] prev;           // Last sample
  logic         primed;         // First sample taken
  logic [W-1:0] next_prev;
  logic         next_primed;
  logic [W-1:0] next_edgePulse;

  // No edge is reported until a first sample exists
  always_comb begin
    next_prev      = sampleIn;
    next_primed    = 1'b1;
    next_edgePulse = {W{RST_LVL}};
    if (primed) begin
      next_edgePulse = (sampleIn & ~prev & riseEn) |
                       (~sampleIn & prev & fallEn);
    end
  end

  // State registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev      <= {W{RST_LVL}};
      primed    <= RST_LVL;
      edgePulse <= {W{RST_LVL}};
    end else begin
      prev      <= next_prev;
      primed    <= next_primed;
      edgePulse <= next_edgePulse;
    end
  end

  a_edge_fall_seen: assert property (
    @(posedge sys_clk) disable iff (rst)
    primed && |(~sampleIn & prev & fallEn) |=> |edgePulse)
    else $error("enabled falling edge not reported");
endmodule : ppm_edge_detect

// ===== hdl/ppm_pin_bank.sv
// Registered pin drivers for every bidirectional port pin.
// Assumes the caller resolves mode, pull-up and open-drain per bit.
`timescale 1ns/100ps
module ppm_pin_bank
  import ppm_pkg::*;
#(
  parameter int unsigned W = NB // Pins in the bank
) (
  input  wire logic         sys_clk, // System clock
  input  wire logic         rst,     // Async reset
  ppm_pin_if.bank           pins,    // Pin group
  input  wire logic [W-1:0] dirIn,   // 1 = input
  input  wire logic [W-1:0] latch,   // Output latch
  input  wire logic [W-1:0] altSel,  // 1 = alternate
  input  wire logic [W-1:0] altOut,  // Alternate data
  input  wire logic [W-1:0] altOe,   // Alternate drive
  input  wire logic [W-1:0] pullReq, // Pull-up wanted
  input  wire logic [W-1:0] odMask   // Open-drain bits
);
  logic [W-1:0] drive;         // Pin should be driven
  logic [W-1:0] level;         // Level to present
  logic [W-1:0] sensed;        // Pin read, not latch
  logic [W-1:0] next_pinOut;
  logic [W-1:0] next_pinOe;
  logic [W-1:0] next_readData;

  // Open-drain bits only ever pull low
  always_comb begin
    drive         = (altSel & altOe) | (~altSel & ~dirIn);
    level         = (altSel & altOut) | (~altSel & latch);
    sensed        = dirIn | altSel;
    next_pinOut   = level & ~odMask;
    next_pinOe    = drive & ~(odMask & level);
    next_readData = (sensed & pins.pinIn) | (~sensed & latch);
  end

  // Output registers; released and unpulled at reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins.pinOut   <= {W{RST_LVL}};
      pins.pinOe    <= {W{RST_LVL}};
      pins.pullEn   <= {W{RST_LVL}};
      pins.readData <= {W{RST_LVL}};
    end else begin
      pins.pinOut   <= next_pinOut;
      pins.pinOe    <= next_pinOe;
      pins.pullEn   <= pullReq;
      pins.readData <= next_readData;
    end
  end

  a_od_never_high: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 (($past(odMask) & pins.pinOut) == '0))
    else $error("open-drain pin driven high");
endmodule : ppm_pin_bank

// ===== dv/ppm_board_model.sv
// Board side of the pins: chip drive, board drive, pull-up.
// Assumes one sys_clk; a pin nobody holds toggles each cycle.
`timescale 1ns/100ps
module ppm_board_model
  import ppm_pkg::*;
(
  input  wire logic          sys_clk, // System clock
  input  wire logic [NB-1:0] pinOut,  // Chip drive level
  input  wire logic [NB-1:0] pinOe,   // Chip drive enable
  input  wire logic [NB-1:0] pullEn,  // Chip pull-up
  input  wire logic [NB-1:0] extVal,  // Board drive level
  input  wire logic [NB-1:0] extDrv,  // Board drive enable
  output logic      [NB-1:0] pinIn    // Resolved level
);
  logic flt = 1'b0; // Floating pattern
  // Toggle so a floating pin never reads steady
  always @(posedge sys_clk) begin
    flt <= ~flt;
  end
  // Chip first, then board, then pull-up
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extDrv[i]) pinIn[i] = extVal[i];
      else if (pullEn[i]) pinIn[i] = 1'b1;
      else pinIn[i] = flt;
    end
  end
endmodule : ppm_board_model

// ===== dv/test_ppm_port_ctrl.sv
// Testbench for the port pin mode controller.
// Assumes the board model closes the pin loop.
`timescale 1ns/100ps
module test_ppm_port_ctrl
  import ppm_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic [NB-1:0] pinIn, pinOut, pinOe, pullEn, portRead;
  logic [NB-1:0] portDir = '1, portLatch = '0, portAlt = '0;
  logic [NB-1:0] pullCfg = '0, extVal = '0, extDrv = '1;
  logic [7:0] pullupOption = 8'h00, port2OpenDrainCtrl = 8'h00;
  logic [7:0] p2AltOut = 8'h00, p2AltOe = 8'h00;
  logic [7:0] p3AltOut = 8'h00, p3AltOe = 8'h00;
  logic [P7_W-1:0] p7AltOut = '0, p7AltOe = '0;
  logic [P10_W-1:0] p10AltOut = '0, p10AltOe = '0;
  logic extAccessStatus = 1'b0, lowAddrDataOe = 1'b0;
  logic readStrobe = 1'b0, writeStrobe = 1'b0;
  logic addressLatchStrobe = 1'b0, waitEnable = 1'b0;
  logic [7:0] lowAddrDataBus = 8'h00, midAddressBus = 8'h00;
  logic [7:0] lowAddressBus = 8'h00;
  logic [3:0] highAddressBus = 4'h0;
  logic [P1_W-1:0] analogInputs = 8'h00, analogSel = 8'h00, port1Read;
  logic [P0_W-1:0] riseEdgeEnable = '0, fallEdgeEnable = '0;
  logic [P0_W-1:0] extIrqInputs;
  logic nmiSelect = 1'b0, keyReturnClear = 1'b0;
  logic nmiRequest, rtpTrigger, keyReturnIrqFlag;
  int fails = 0, checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////
  ppm_port_ctrl dut (.*);
  ppm_board_model board (.*);
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [NB-1:0] got, input logic [NB-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Port 0 direction and pull per bit; port 9 never pulls
  task automatic t_port0();
    @(posedge sys_clk);
    portDir[1:0] <= 2'h0;
    portLatch[0] <= 1'b1;
    pullCfg[2:1] <= 2'h3;
    pullCfg[P9_BASE] <= 1'b1;
    tick(2);
    chk(pinOe, 68'h3);
    chk(pinOut & pinOe, 68'h1);
    chk(pullEn, 68'h6);
    chk(portRead, 68'h1);
    @(posedge sys_clk);
    portDir <= '1;
    portLatch <= '0;
    pullCfg <= '0;
  endtask : t_port0
  // Port-wide pulls; port 5 bus while port 4 stays port
  task automatic t_wide();
    @(posedge sys_clk);
    pullupOption <= 8'h30;
    portAlt[P5_BASE+:16] <= 16'hFFFF;
    midAddressBus <= 8'hA5;
    highAddressBus <= 4'hC;
    addressLatchStrobe <= 1'b1;
    tick(2);
    chk(pullEn, 68'hFFFF << P4_BASE);
    chk(pinOe, 68'hBFFF << P5_BASE);
    chk(pinOut & pinOe, 68'h8CA5 << P5_BASE);
    chk(pinOut[P6_BASE+:8], 68'h8C);
    @(posedge sys_clk);
    pullupOption <= 8'h00;
    portAlt <= '0;
  endtask : t_wide
  // Open-drain bit 5 of port 2 never drives high
  task automatic t_od();
    @(posedge sys_clk);
    portAlt[P2_BASE+5] <= 1'b1;
    p2AltOut <= 8'h20;
    p2AltOe <= 8'h20;
    port2OpenDrainCtrl <= 8'h20;
    tick(2);
    chk(pinOe[P2_BASE+5], 68'h0);
    @(posedge sys_clk);
    p2AltOut <= 8'h00;
    portAlt[P3_BASE+P3_EXA_BIT] <= 1'b1;
    extAccessStatus <= 1'b1;
    tick(2);
    chk({pinOe[P2_BASE+5], pinOut[P2_BASE+5]}, 68'h2);
    chk({pinOe[P3_BASE+7], pinOut[P3_BASE+7]}, 68'h3);
    @(posedge sys_clk);
    portAlt <= '0;
    p2AltOe <= 8'h00;
  endtask : t_od
  // Interrupt edges, non-maskable route and trigger
  task automatic t_edge();
    @(posedge sys_clk);
    portAlt[P0_W-1:0] <= '1;
    riseEdgeEnable <= 7'h04;
    fallEdgeEnable <= 7'h01;
    nmiSelect <= 1'b1;
    tick(3);
    @(posedge sys_clk);
    extVal[2:0] <= 3'h5;
    tick(2);
    chk({nmiRequest, rtpTrigger, extIrqInputs}, 68'h180);
    tick(1);
    chk({nmiRequest, rtpTrigger, extIrqInputs}, 68'h0);
    @(posedge sys_clk);
    nmiSelect <= 1'b0;
    fallEdgeEnable <= 7'h05;
    @(posedge sys_clk);
    extVal[2:0] <= 3'h0;
    tick(2);
    chk({nmiRequest, rtpTrigger, extIrqInputs}, 68'h85);
    @(posedge sys_clk);
    portAlt <= '0;
    riseEdgeEnable <= '0;
    fallEdgeEnable <= '0;
  endtask : t_edge
  // Key-return flag set by a fall, held, then cleared
  task automatic t_key();
    @(posedge sys_clk);
    extVal[P8_BASE+3] <= 1'b1;
    tick(3);
    @(posedge sys_clk);
    extVal[P8_BASE+3] <= 1'b0;
    tick(4);
    chk(keyReturnIrqFlag, 68'h1);
    @(posedge sys_clk);
    keyReturnClear <= 1'b1;
    @(posedge sys_clk);
    keyReturnClear <= 1'b0;
    tick(1);
    chk(keyReturnIrqFlag, 68'h0);
  endtask : t_key
  // Port 1 read with analog bits
  task automatic t_port1();
    @(posedge sys_clk);
    analogInputs <= 8'hFF;
    analogSel <= 8'h0F;
    tick(2);
    chk(port1Read, 68'hF0);
  endtask : t_port1
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    tick(11);
    chk(pinOe | pullEn | pinOut, 68'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    tick(2);
    chk(pinOe | pullEn, 68'h0);
    t_port0();
    t_wide();
    t_od();
    t_edge();
    t_key();
    t_port1();
    wrap_up();
  end
endmodule : test_ppm_port_ctrl
